// *** gain_power_defs.svh ***
// Offsets, field positions, reset values and timing counts of the block.
//
// Notes on behaviour
// [R1] Coarse gain 3.5 dB, one enable bit.
// [R2] Fine gain 0 to 6 dB in 1 dB.
// [R3] Reset gives zero gain: coarse off, fine zero.
// [R4] Six clock buffer levels, rising amplification.
// [R5] Clock buffer level resets to one.
// [R6] Chip sleep powers down converters, references, PLL, drivers.
// [R7] Chip sleep puts all serial outputs high-impedance.
// [R8] Data valid within 100 us after sleep.
// [R9] One standby bit per converter, independent.
// [R10] Standby keeps serial drivers powered.
// [R11] Standby wake within 200 sample clocks.
// [R12] Slow or weak clock enters clock stop.
// [R13] Clock stop powers down; 100 us wake.
// [R14] Register bit selects external reference mode.
// [R15] Data valid low until wake interval ends.
// [R16] Per-channel wake count restarts on standby.
`ifndef GAIN_POWER_DEFS_SVH
`define GAIN_POWER_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W          8
`define OFF_GAIN        8'h00
`define OFF_POWER       8'h04
`define OFF_STATUS      8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_COARSE        0
`define F_FINE_LSB      1
`define F_LEVEL_LSB     4
`define F_EXTREF        7
`define F_SLEEP         0
`define F_STBY_LSB      1
`define F_VALID_LSB     0
`define F_STATE_LSB     4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_COARSE      1'b0
`define RST_FINE        3'h0
`define RST_LEVEL       3'h1
`define RST_EXTREF      1'b0
`define FINE_MAX        3'h6
`define LEVEL_MAX       3'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define CHIP_WAKE_US    100
`define CHIP_WAKE_CYC   ((`CHIP_WAKE_US * 1000) / `CLK_PERIOD_NS)
`define STBY_WAKE_CYC   200

`endif

// *** gain_power_pkg.sv ***
// Types shared by the gain and power control block.
package gain_power_pkg;

   // ----------------------------------------------------------------
   // Chip-wide power state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_SLEEP   = 2'b01,
      ST_CLKSTOP = 2'b10,
      ST_WAKE    = 2'b11
   } pwr_state_t;

endpackage : gain_power_pkg

// *** wake_counter.sv ***
// Wake interval counter: done rises N enabled edges after hold falls.
`timescale 1ns/1ps
`default_nettype none

module wake_counter #(
   parameter int N = 200
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic hold,
   output logic      done
);

   localparam int W = $clog2(N + 1);
   localparam logic [W-1:0] LAST = W'(N - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         done_q;
   logic         done_d;

   // Hold clears the count so every new sleep restarts the wait.
   always_comb begin
      cnt_d  = cnt_q;
      done_d = done_q;
      if (hold) begin                                  // [R16]
         cnt_d  = '0;
         done_d = 1'b0;
      end else if (!done_q) begin
         if (cnt_q == LAST) begin                      // [R11]
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   // Clock enable freezes the count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;

   property p_done_at_last;
      @(posedge clk) disable iff (!rst_n)
      $rose(done_q) |-> $past(cnt_q) == LAST;
   endproperty
   a_done_at_last: // [R11]
      assert property (p_done_at_last)
      else $error("Wake done rose before full count.");

   property p_hold_restarts;
      @(posedge clk) disable iff (!rst_n)
      (hold && ce) |=> (cnt_q == '0) && !done_q;
   endproperty
   a_hold_restarts: // [R16]
      assert property (p_hold_restarts)
      else $error("Hold did not restart the wake count.");

endmodule : wake_counter

`default_nettype wire

// *** gain_code_clamp.sv ***
// Clamps written gain codes to the legal range.
`timescale 1ns/1ps
`default_nettype none
`include "gain_power_defs.svh"

module gain_code_clamp (
   input  wire logic [2:0] fine_in,
   input  wire logic [2:0] level_in,
   output logic      [2:0] fine_out,
   output logic      [2:0] level_out
);

   // Codes above the top step map to the top step, never wrap.
   always_comb begin
      fine_out  = (fine_in > `FINE_MAX) ? `FINE_MAX : fine_in;   // [R2]
      level_out = (level_in > `LEVEL_MAX) ? `LEVEL_MAX
                                          : level_in;          // [R4]
   end

endmodule : gain_code_clamp

`default_nettype wire

// *** adc_gain_and_power_control.sv ***
// Gain settings, power states and wake timing with an APB register slave.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gain_power_defs.svh"

module adc_gain_and_power_control #(
   parameter int CHIP_WAKE_CYC = `CHIP_WAKE_CYC,
   parameter int STBY_WAKE_CYC = `STBY_WAKE_CYC,
   parameter int NUM_CH        = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [`ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              clk_rate_low,
   input  wire logic              clk_amp_low,
   output logic                   coarse_gain_en,
   output logic      [2:0]        fine_gain_code,
   output logic      [2:0]        sample_clock_amp_level,
   output logic                   ext_ref_en,
   output logic                   common_mode_pin_oe,
   output logic      [NUM_CH-1:0] pd_converters,
   output logic                   pd_reference,
   output logic                   pd_bit_clock_pll,
   output logic                   pd_serial_drivers,
   output logic                   serial_out_oe,
   output logic      [NUM_CH-1:0] data_valid,
   output logic                   clock_stop
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              coarse_q, coarse_d;
   logic [2:0]        fine_q, fine_d;
   logic [2:0]        level_q, level_d;
   logic              extref_q, extref_d;
   logic              full_chip_sleep_bit_q, full_chip_sleep_bit_d;
   logic [NUM_CH-1:0] per_converter_sleep_bits_q;
   logic [NUM_CH-1:0] per_converter_sleep_bits_d;
   logic              pready_q, pready_d;
   logic              pslverr_q, pslverr_d;
   logic [31:0]       prdata_q, prdata_d;
   logic [2:0]        fine_clamped;
   logic [2:0]        level_clamped;
   logic              wr_take;
   logic              rd_take;

   gain_power_pkg::pwr_state_t state_q, state_d;
   logic              chip_wake_done;
   logic [NUM_CH-1:0] ch_wake_done;
   logic              stop_req;

   logic              o_coarse_q, o_extref_q, o_cm_oe_q;
   logic [2:0]        o_fine_q, o_level_q;
   logic [NUM_CH-1:0] o_pd_conv_q, o_valid_q;
   logic              o_pd_ref_q, o_pd_pll_q, o_pd_ser_q;
   logic              o_ser_oe_q, o_stop_q;
   logic              o_coarse_d, o_extref_d, o_cm_oe_d;
   logic [2:0]        o_fine_d, o_level_d;
   logic [NUM_CH-1:0] o_pd_conv_d, o_valid_d;
   logic              o_pd_ref_d, o_pd_pll_d, o_pd_ser_d;
   logic              o_ser_oe_d, o_stop_d;

   // ----------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------

   // Out-of-range gain codes are clamped before they are stored.
   gain_code_clamp u_clamp (
      .fine_in   (pwdata[`F_FINE_LSB +: 3]),
      .level_in  (pwdata[`F_LEVEL_LSB +: 3]),
      .fine_out  (fine_clamped),
      .level_out (level_clamped)
   );

   // One wait state: pready rises in the second access cycle, so
   // read data also comes straight from a flip-flop.
   always_comb begin
      wr_take  = psel && penable && pready_q && pwrite;
      rd_take  = psel && penable && !pready_q && !pwrite;
      pready_d = psel && penable && !pready_q;
      pslverr_d = 1'b0;
      prdata_d  = '0;
      coarse_d = coarse_q;
      fine_d   = fine_q;
      level_d  = level_q;
      extref_d = extref_q;
      full_chip_sleep_bit_d      = full_chip_sleep_bit_q;
      per_converter_sleep_bits_d = per_converter_sleep_bits_q;
      if (paddr == `OFF_GAIN) begin
         prdata_d[`F_COARSE]          = coarse_q;
         prdata_d[`F_FINE_LSB +: 3]   = fine_q;
         prdata_d[`F_LEVEL_LSB +: 3]  = level_q;
         prdata_d[`F_EXTREF]          = extref_q;
         if (wr_take) begin
            coarse_d = pwdata[`F_COARSE];             // [R1]
            fine_d   = fine_clamped;                  // [R2]
            level_d  = level_clamped;                 // [R4]
            extref_d = pwdata[`F_EXTREF];             // [R14]
         end
      end else if (paddr == `OFF_POWER) begin
         prdata_d[`F_SLEEP]                = full_chip_sleep_bit_q;
         prdata_d[`F_STBY_LSB +: NUM_CH]   = per_converter_sleep_bits_q;
         if (wr_take) begin
            full_chip_sleep_bit_d      = pwdata[`F_SLEEP];  // [R6]
            per_converter_sleep_bits_d =
               pwdata[`F_STBY_LSB +: NUM_CH];               // [R9]
         end
      end else if (paddr == `OFF_STATUS) begin
         prdata_d[`F_VALID_LSB +: NUM_CH] = o_valid_q;
         prdata_d[`F_STATE_LSB +: 2]      = state_q;
      end else begin
         pslverr_d = pready_d;    // Unmapped: error, reads zero.
      end
      if (!rd_take) begin
         prdata_d = '0;
      end
   end

   // Register storage; reset applies zero gain and level one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coarse_q  <= `RST_COARSE;                    // [R3]
         fine_q    <= `RST_FINE;                      // [R3]
         level_q   <= `RST_LEVEL;                     // [R5]
         extref_q  <= `RST_EXTREF;
         full_chip_sleep_bit_q      <= 1'b0;
         per_converter_sleep_bits_q <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else if (ce) begin
         coarse_q  <= coarse_d;
         fine_q    <= fine_d;
         level_q   <= level_d;
         extref_q  <= extref_d;
         full_chip_sleep_bit_q      <= full_chip_sleep_bit_d;
         per_converter_sleep_bits_q <= per_converter_sleep_bits_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Chip-wide power state and wake timers
   // ----------------------------------------------------------------

   // Either detector flag means the sample clock is unusable.
   assign stop_req = clk_rate_low || clk_amp_low;     // [R12]

   // Sleep outranks clock stop; leaving either for run goes through the long wake.
   always_comb begin
      state_d = state_q;
      case (state_q)
         gain_power_pkg::ST_RUN,
         gain_power_pkg::ST_WAKE: begin
            if (full_chip_sleep_bit_q) begin
               state_d = gain_power_pkg::ST_SLEEP;    // [R6]
            end else if (stop_req) begin
               state_d = gain_power_pkg::ST_CLKSTOP;  // [R12]
            end else if (state_q == gain_power_pkg::ST_WAKE &&
                         chip_wake_done) begin
               state_d = gain_power_pkg::ST_RUN;      // [R8]
            end
         end
         gain_power_pkg::ST_SLEEP: begin
            if (!full_chip_sleep_bit_q) begin
               state_d = stop_req ? gain_power_pkg::ST_CLKSTOP
                                  : gain_power_pkg::ST_WAKE;
            end
         end
         gain_power_pkg::ST_CLKSTOP: begin
            if (full_chip_sleep_bit_q) begin
               state_d = gain_power_pkg::ST_SLEEP;
            end else if (!stop_req) begin
               state_d = gain_power_pkg::ST_WAKE;     // [R13]
            end
         end
         default: state_d = gain_power_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= gain_power_pkg::ST_RUN;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // The long wait only runs in the wake state. Entering wake, leaving
   // it and the output register cost three edges, so the counter runs
   // three short to keep the whole wake within CHIP_WAKE_CYC.
   wake_counter #(.N(CHIP_WAKE_CYC - 3)) u_chip_wake (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (ce),
      .hold  (state_q != gain_power_pkg::ST_WAKE),   // [R8] [R13]
      .done  (chip_wake_done)
   );

   // Each channel times its own standby exit; the output register adds
   // one edge, so the counter runs one short of STBY_WAKE_CYC.
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      wake_counter #(.N(STBY_WAKE_CYC - 1)) u_ch_wake (
         .clk   (pclk),
         .rst_n (presetn),
         .ce    (ce),
         .hold  (per_converter_sleep_bits_q[i]),     // [R11] [R16]
         .done  (ch_wake_done[i])
      );
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------

   // Standby only touches the converter cores, never the drivers.
   always_comb begin
      o_coarse_d  = coarse_q;                         // [R1]
      o_fine_d    = fine_q;                           // [R2]
      o_level_d   = level_q;                          // [R4]
      o_extref_d  = extref_q;                         // [R14]
      o_cm_oe_d   = !extref_q;                        // [R14]
      o_pd_ref_d  = state_q == gain_power_pkg::ST_SLEEP;
      o_pd_pll_d  = state_q == gain_power_pkg::ST_SLEEP;
      o_pd_ser_d  = state_q == gain_power_pkg::ST_SLEEP ||
                    state_q == gain_power_pkg::ST_CLKSTOP;  // [R10]
      o_ser_oe_d  = state_q != gain_power_pkg::ST_SLEEP;    // [R7]
      o_stop_d    = state_q == gain_power_pkg::ST_CLKSTOP;
      o_pd_conv_d = per_converter_sleep_bits_q |
                    {NUM_CH{o_pd_ser_d}};             // [R6] [R13]
      o_valid_d   = {NUM_CH{state_q == gain_power_pkg::ST_RUN}} &
                    ~per_converter_sleep_bits_q &
                    ch_wake_done;                     // [R15]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         o_coarse_q  <= `RST_COARSE;
         o_fine_q    <= `RST_FINE;
         o_level_q   <= `RST_LEVEL;
         o_extref_q  <= `RST_EXTREF;
         o_cm_oe_q   <= 1'b1;
         o_pd_ref_q  <= 1'b0;
         o_pd_pll_q  <= 1'b0;
         o_pd_ser_q  <= 1'b0;
         o_ser_oe_q  <= 1'b1;
         o_stop_q    <= 1'b0;
         o_pd_conv_q <= '0;
         o_valid_q   <= '0;
      end else if (ce) begin
         o_coarse_q  <= o_coarse_d;
         o_fine_q    <= o_fine_d;
         o_level_q   <= o_level_d;
         o_extref_q  <= o_extref_d;
         o_cm_oe_q   <= o_cm_oe_d;
         o_pd_ref_q  <= o_pd_ref_d;
         o_pd_pll_q  <= o_pd_pll_d;
         o_pd_ser_q  <= o_pd_ser_d;
         o_ser_oe_q  <= o_ser_oe_d;
         o_stop_q    <= o_stop_d;
         o_pd_conv_q <= o_pd_conv_d;
         o_valid_q   <= o_valid_d;
      end
   end

   assign prdata                 = prdata_q;
   assign pready                 = pready_q;
   assign pslverr                = pslverr_q;
   assign coarse_gain_en         = o_coarse_q;
   assign fine_gain_code         = o_fine_q;
   assign sample_clock_amp_level = o_level_q;
   assign ext_ref_en             = o_extref_q;
   assign common_mode_pin_oe     = o_cm_oe_q;
   assign pd_converters          = o_pd_conv_q;
   assign pd_reference           = o_pd_ref_q;
   assign pd_bit_clock_pll       = o_pd_pll_q;
   assign pd_serial_drivers      = o_pd_ser_q;
   assign serial_out_oe          = o_ser_oe_q;
   assign data_valid             = o_valid_q;
   assign clock_stop             = o_stop_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Helper: set once software has written the gain register.
   logic gain_touched_q;
   logic [31:0] wake_cycles_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_touched_q <= 1'b0;
         wake_cycles_q  <= '0;
      end else if (ce) begin
         if (wr_take && paddr == `OFF_GAIN) begin
            gain_touched_q <= 1'b1;
         end
         wake_cycles_q <= (state_q == gain_power_pkg::ST_WAKE) ?
                          wake_cycles_q + 32'h0000_0001 : '0;
      end
   end

   property p_fine_range;
      fine_gain_code <= `FINE_MAX;
   endproperty
   a_fine_range: // [R2]
      assert property (p_fine_range) else $error("Fine gain out of range.");

   property p_level_range;
      sample_clock_amp_level <= `LEVEL_MAX;
   endproperty
   a_level_range: // [R4]
      assert property (p_level_range) else $error("Clock level too high.");

   property p_gain_default;
      !gain_touched_q |-> !coarse_q && fine_q == `RST_FINE;
   endproperty
   a_gain_default: // [R3]
      assert property (p_gain_default) else $error("Gain not zero.");

   property p_level_default;
      !gain_touched_q |-> level_q == `RST_LEVEL;
   endproperty
   a_level_default: // [R5]
      assert property (p_level_default) else $error("Level not one.");

   property p_coarse_follows;
      (wr_take && paddr == `OFF_GAIN && ce) ##1 ce
         |=> coarse_gain_en == $past(pwdata[`F_COARSE], 2);
   endproperty
   a_coarse_follows: // [R1]
      assert property (p_coarse_follows) else $error("Coarse gain stale.");

   property p_sleep_pd;
      (state_q == gain_power_pkg::ST_SLEEP && ce) |=>
         &pd_converters && pd_reference && pd_bit_clock_pll &&
         pd_serial_drivers && !serial_out_oe;
   endproperty
   a_sleep_pd: // [R6] [R7]
      assert property (p_sleep_pd) else $error("Sleep not applied.");

   property p_wake_bound;
      wake_cycles_q <= 32'(CHIP_WAKE_CYC);
   endproperty
   a_wake_bound: // [R8] [R13]
      assert property (p_wake_bound) else $error("Wake took too long.");

   property p_stop_enter;
      (stop_req && !full_chip_sleep_bit_q && ce) ##1 ce
         |=> clock_stop;
   endproperty
   a_stop_enter: // [R12]
      assert property (p_stop_enter) else $error("Clock stop missed.");

   property p_standby_drivers;
      (state_q == gain_power_pkg::ST_RUN && ce) |=>
         !pd_serial_drivers && serial_out_oe;
   endproperty
   a_standby_drivers: // [R10]
      assert property (p_standby_drivers) else $error("Drivers off.");

   property p_ext_ref;
      ext_ref_en |-> !common_mode_pin_oe;
   endproperty
   a_ext_ref: // [R14]
      assert property (p_ext_ref) else $error("Common-mode pin driven.");

   property p_valid_quiet;
      (state_q != gain_power_pkg::ST_RUN && ce) |=> data_valid == '0;
   endproperty
   a_valid_quiet: // [R15]
      assert property (p_valid_quiet) else $error("Valid while asleep.");

   property p_valid_ch;
      data_valid[0] |-> $past(ch_wake_done[0]) &&
                        !$past(per_converter_sleep_bits_q[0]);
   endproperty
   a_valid_ch: // [R9] [R11]
      assert property (p_valid_ch) else $error("Channel valid early.");

endmodule : adc_gain_and_power_control

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the gain and power control block.
`timescale 1ns/1ps
`default_nettype none
`include "gain_power_defs.svh"

module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Chip wake shortened to keep the run brief; standby keeps 200.
   localparam int CHIP_CYC = 20;
   localparam int STBY_CYC = 200;
   logic        pclk, presetn, ce, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic        pready, pslverr, last_err, clk_rate_low, clk_amp_low;
   logic        coarse_gain_en, ext_ref_en, common_mode_pin_oe;
   logic [2:0]  fine_gain_code, sample_clock_amp_level;
   logic [3:0]  pd_converters, data_valid;
   logic        pd_reference, pd_bit_clock_pll, pd_serial_drivers;
   logic        serial_out_oe, clock_stop;
   int          err_total, checked, cyc, n;

   adc_gain_and_power_control #(
      .CHIP_WAKE_CYC(CHIP_CYC), .STBY_WAKE_CYC(STBY_CYC), .NUM_CH(4)
   ) dut_u (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clk_rate_low(clk_rate_low),
      .clk_amp_low(clk_amp_low), .coarse_gain_en(coarse_gain_en),
      .fine_gain_code(fine_gain_code),
      .sample_clock_amp_level(sample_clock_amp_level),
      .ext_ref_en(ext_ref_en), .common_mode_pin_oe(common_mode_pin_oe),
      .pd_converters(pd_converters), .pd_reference(pd_reference),
      .pd_bit_clock_pll(pd_bit_clock_pll),
      .pd_serial_drivers(pd_serial_drivers),
      .serial_out_oe(serial_out_oe), .data_valid(data_valid),
      .clock_stop(clock_stop)
   );

   // Free-running 50 MHz clock.
   always #10 pclk = ~pclk;

   // Hang guard: the whole run needs well under 5000 cycles.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; starts after an edge so psel never toggles twice.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdq      = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Cycles until every channel in the mask reports valid data.
   task automatic cnt_valid(input logic [3:0] m);
      n = 0;
      while ((data_valid & m) !== m && n < 1000) begin
         n++;
         @(posedge pclk);
      end
   endtask : cnt_valid

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(data_valid, 4'h0);
      cnt_valid(4'hF);
      chk(32'(n >= STBY_CYC - 4 && n <= STBY_CYC + 1), 32'h1);
      chk(coarse_gain_en, 1'b0);
      chk(fine_gain_code, 3'h0);
      chk(sample_clock_amp_level, 3'h1);
      apb(1'b0, `OFF_GAIN, 32'h0);
      chk(rdq, 32'h10);
   endtask : t_reset

   task automatic t_gain();
      // Fine code 7 and level codes 7 and 6 check that out-of-range codes are clamped.
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `OFF_GAIN, 32'(i[0] | (i << 1) | ((7 - i) << 4)));
         repeat (2) @(posedge pclk);
         chk(coarse_gain_en, i[0]);
         chk(fine_gain_code, (i > 6) ? 32'h6 : 32'(i));
         chk(sample_clock_amp_level, (i < 2) ? 32'h5 : 32'(7 - i));
      end
      apb(1'b1, `OFF_GAIN, 32'h80);
      repeat (2) @(posedge pclk);
      chk({ext_ref_en, common_mode_pin_oe}, 2'h2);
      apb(1'b1, 8'h0C, 32'hFF);
      chk(last_err, 1'b1);
      apb(1'b1, `OFF_GAIN, 32'h0);
   endtask : t_gain

   task automatic t_sleep();
      apb(1'b1, `OFF_POWER, 32'h1);
      repeat (4) @(posedge pclk);
      chk(pd_converters, 4'hF);
      chk({pd_reference, pd_bit_clock_pll, pd_serial_drivers}, 3'h7);
      chk(serial_out_oe, 1'b0);
      chk(data_valid, 4'h0);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rdq, 32'h10);
      apb(1'b1, `OFF_POWER, 32'h0);
      cnt_valid(4'hF);
      chk(32'(n >= CHIP_CYC - 4 && n <= CHIP_CYC + 1), 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rdq, 32'h0F);
      chk(serial_out_oe, 1'b1);
   endtask : t_sleep

   task automatic t_stby();
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `OFF_POWER, 32'(2 << c));
         repeat (3) @(posedge pclk);
         chk(pd_converters, 32'(1 << c));
         chk({serial_out_oe, pd_serial_drivers}, 2'h2);
      end
      // Let every channel settle before restarting channel 1 alone.
      apb(1'b1, `OFF_POWER, 32'h0);
      cnt_valid(4'hF);
      apb(1'b1, `OFF_POWER, 32'h4);
      apb(1'b1, `OFF_POWER, 32'h0);
      repeat (100) @(posedge pclk);
      chk(data_valid, 4'hD);
      apb(1'b1, `OFF_POWER, 32'h4);
      apb(1'b1, `OFF_POWER, 32'h0);
      cnt_valid(4'h2);
      chk(32'(n >= STBY_CYC - 4 && n <= STBY_CYC + 1), 32'h1);
   endtask : t_stby

   // Each detector alone must force the clock-stop state.
   task automatic t_clkstop();
      // Clock enable low freezes the state, so a detector flag is ignored.
      ce           <= 1'b0;
      clk_rate_low <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(clock_stop, 1'b0);
      ce           <= 1'b1;
      clk_rate_low <= 1'b0;
      @(posedge pclk);
      for (int d = 0; d < 2; d++) begin
         clk_rate_low <= (d == 0);
         clk_amp_low  <= (d == 1);
         repeat (6) @(posedge pclk);
         chk(clock_stop, 1'b1);
         chk({pd_converters, pd_serial_drivers}, 5'h1F);
         chk(data_valid, 4'h0);
         clk_rate_low <= 1'b0;
         clk_amp_low  <= 1'b0;
         @(posedge pclk);
         cnt_valid(4'hF);
         chk(32'(n >= CHIP_CYC - 4 && n <= CHIP_CYC + 1), 32'h1);
      end
   endtask : t_clkstop

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // Main sequence: hold reset for 16 cycles, then run the scenarios.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, clk_rate_low, clk_amp_low} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gain();
      t_sleep();
      t_stby();
      t_clkstop();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
